// File: hw/tmop_defs.vh
`ifndef TMOP_DEFS_VH
`define TMOP_DEFS_VH

// Register byte offsets
`define TMOP_OFF_IDLE_CTL 8'h04
`define TMOP_OFF_CMP_MODE 8'h18
`define TMOP_OFF_CHAN_EN 8'h20
`define TMOP_OFF_CMP_VALUE 8'h34
`define TMOP_OFF_PROTECT 8'h44
`define TMOP_OFF_BURST_CFG 8'h48
`define TMOP_OFF_BURST_WIN 8'h4c
`define TMOP_OFF_OPTION 8'hfc

// Reset value of every register
`define TMOP_RST_REG 16'h0000

// output_protect_control fields
`define TMOP_B_PRIMARY_OUTPUT_ENABLE 15
`define TMOP_B_AUTO_OUTPUT_ENABLE 14
`define TMOP_B_BREAK_POLARITY 13
`define TMOP_B_BREAK_ENABLE 12
`define TMOP_B_ROS 11
`define TMOP_B_IOS 10
`define TMOP_B_PROTECT_LEVEL_HI 9
`define TMOP_B_PROTECT_LEVEL_LO 8
`define TMOP_B_DT_HI 7
`define TMOP_B_DT_LO 0

// Idle level fields
`define TMOP_B_IDLE 8
`define TMOP_B_IDLE_N 9

// Compare mode fields
`define TMOP_B_MODE_HI 1
`define TMOP_B_MODE_LO 0
`define TMOP_B_SHADOW 3
`define TMOP_B_ACT_HI 6
`define TMOP_B_ACT_LO 4
`define TMOP_MODE_OUTPUT 2'h0

// Channel enable fields
`define TMOP_B_EN 0
`define TMOP_B_POL 1
`define TMOP_B_NEN 2
`define TMOP_B_NPOL 3

// Burst config fields
`define TMOP_B_CNT_HI 12
`define TMOP_B_CNT_LO 8
`define TMOP_B_START_HI 4
`define TMOP_B_START_LO 0

// Option fields
`define TMOP_B_SKIP 1
`define TMOP_B_OUTPUT_OFF_SELECT 0

// Protect levels
`define TMOP_PROTECT_LEVEL_OFF 2'h0
`define TMOP_PROTECT_LEVEL_L3 2'h3

// Dead-time encoding bases
`define TMOP_DT_BASE_MID 10'h040
`define TMOP_DT_BASE_HI 10'h020

// AXI responses
`define TMOP_RESP_OKAY 2'h0
`define TMOP_RESP_SLVERR 2'h2

`endif

// File: hw/tmop_top.v
`timescale 1ns/1ps
`include "tmop_defs.vh"
// How it works
// - Auto enable sets output enable on update
// - Active break clears output enable immediately
// - Outputs need output enable plus channel bits
// - Break polarity selects active pin level
// - Break enable gates pin and clock failure
// - Run off-state select governs disabled outputs
// - Idle off-state select governs outputs when off
// - Level one locks idle, break, dead-time bits
// - Higher levels lock polarity, off-state, compare
// - Protect level writable once after reset
// - Dead time low encodings: x1, x2
// - Dead time high encodings: x8, x16
// - Burst count bounds window accesses
// - Start index selects first window register
// - Window access redirects to start plus index
// - Hardware advances and wraps burst index
// - Same-value compare writes optionally skipped
// - Output off select disables outputs when idle and idle off-state select is clear
module tmop_top (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// AXI4-Lite write address
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [7:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	output wire [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	input wire [7:0] s_axi_araddr,
	// AXI4-Lite read data
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	// Timer kernel events
	input wire update_event,
	input wire compare_ref,
	// Break sources
	input wire break_input_pin,
	input wire clock_monitor,
	// Power stage outputs
	output reg channel_out,
	output reg channel_out_oe,
	output reg channel_out_compl,
	output reg channel_out_compl_oe,
	output wire primary_output_enable
);

	// Bus state
	reg aw_got_q, w_got_q, bvalid_q, rvalid_q;
	reg [1:0] w_strb_q, bresp_q, rresp_q;
	reg [7:0] aw_addr_q;
	reg [15:0] w_data_q;
	reg [31:0] rdata_q;

	// Register fields
	reg idle_level_q, compl_idle_level_q, compare_shadow_enable_q, protect_level_locked_q;
	reg channel_enable_bit_q, channel_polarity_bit_q, compl_channel_enable_bit_q, compl_polarity_bit_q;
	reg primary_output_enable_q, auto_output_enable_q, break_polarity_q, break_enable_q;
	reg run_offstate_select_q, idle_offstate_select_q, same_value_write_skip_q, output_off_select_q;
	reg [1:0] ch_mode_q, protect_level_q;
	reg [2:0] compare_action_q;
	reg [4:0] burst_count_q, burst_start_index_q, burst_idx_q;
	reg [7:0] dead_time_config_q;
	reg [15:0] compare_value_q;

	// Dead-time generator state
	reg ref_q, main_q, compl_q;
	reg [9:0] dt_cnt_q;

	// Read view of one register: hit flag and data
	function [16:0] rd_word;
		input [7:0] a;
		begin
			rd_word = {1'b1, 16'h0000};
			case (a)
				`TMOP_OFF_IDLE_CTL: begin
					rd_word[`TMOP_B_IDLE] = idle_level_q;
					rd_word[`TMOP_B_IDLE_N] = compl_idle_level_q;
				end
				`TMOP_OFF_CMP_MODE: begin
					rd_word[`TMOP_B_MODE_HI:`TMOP_B_MODE_LO] = ch_mode_q;
					rd_word[`TMOP_B_SHADOW] = compare_shadow_enable_q;
					rd_word[`TMOP_B_ACT_HI:`TMOP_B_ACT_LO] = compare_action_q;
				end
				`TMOP_OFF_CHAN_EN: begin
					rd_word[`TMOP_B_EN] = channel_enable_bit_q;
					rd_word[`TMOP_B_POL] = channel_polarity_bit_q;
					rd_word[`TMOP_B_NEN] = compl_channel_enable_bit_q;
					rd_word[`TMOP_B_NPOL] = compl_polarity_bit_q;
				end
				`TMOP_OFF_CMP_VALUE: begin
					rd_word[15:0] = compare_value_q;
				end
				`TMOP_OFF_PROTECT: begin
					rd_word[15:0] = {primary_output_enable_q, auto_output_enable_q, break_polarity_q, break_enable_q,
						run_offstate_select_q, idle_offstate_select_q, protect_level_q, dead_time_config_q};
				end
				`TMOP_OFF_BURST_CFG: begin
					rd_word[`TMOP_B_CNT_HI:`TMOP_B_CNT_LO] = burst_count_q;
					rd_word[`TMOP_B_START_HI:`TMOP_B_START_LO] = burst_start_index_q;
				end
				`TMOP_OFF_OPTION: begin
					rd_word[`TMOP_B_SKIP] = same_value_write_skip_q;
					rd_word[`TMOP_B_OUTPUT_OFF_SELECT] = output_off_select_q;
				end
				default: begin
					rd_word = 17'h0_0000;
				end
			endcase
		end
	endfunction

	// Dead-time length in clock cycles
	function [9:0] dt_len;
		input [7:0] d;
		reg [9:0] t;
		begin
			t = 10'h000;
			dt_len = 10'h000;
			casez (d[7:5])
				3'b0??: begin
					dt_len = {2'b00, d};
				end
				3'b10?: begin
					t = {4'h0, d[5:0]} + `TMOP_DT_BASE_MID;
					dt_len = {t[8:0], 1'b0};
				end
				3'b110: begin
					t = {5'h00, d[4:0]} + `TMOP_DT_BASE_HI;
					dt_len = {t[6:0], 3'b000};
				end
				default: begin
					t = {5'h00, d[4:0]} + `TMOP_DT_BASE_HI;
					dt_len = {t[5:0], 4'h0};
				end
			endcase
		end
	endfunction

	// Burst window redirect target
	wire [5:0] win_sum = {1'b0, burst_start_index_q} + {1'b0, burst_idx_q};
	wire [7:0] win_addr = {win_sum, 2'b00};
	wire aw_is_win = ({aw_addr_q[7:2], 2'b00} == `TMOP_OFF_BURST_WIN);
	wire ar_is_win = ({s_axi_araddr[7:2], 2'b00} == `TMOP_OFF_BURST_WIN);
	wire [7:0] wr_addr = aw_is_win ? win_addr : {aw_addr_q[7:2], 2'b00};
	wire [7:0] rd_addr = ar_is_win ? win_addr : {s_axi_araddr[7:2], 2'b00};

	// Handshakes
	assign s_axi_awready = ~aw_got_q & ~bvalid_q;
	assign s_axi_wready = ~w_got_q & ~bvalid_q;
	assign s_axi_arready = ~rvalid_q & ~aw_got_q & ~w_got_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	wire ar_fire = s_axi_arvalid & s_axi_arready;
	wire wr_go = aw_got_q & w_got_q & ~bvalid_q;

	// Write merge with byte strobes
	wire [16:0] wr_view = rd_word(wr_addr);
	wire [16:0] rd_view = rd_word(rd_addr);
	wire wr_hit = wr_view[16];
	wire [15:0] wr_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire [15:0] wd = (wr_view[15:0] & ~wr_mask) | (w_data_q & wr_mask);
	wire wr_en = wr_go & wr_hit;
	wire wr_protect_level = wr_en & (wr_addr == `TMOP_OFF_PROTECT);

	// Protection levels
	wire lock1 = (protect_level_q != `TMOP_PROTECT_LEVEL_OFF);
	wire lock2 = protect_level_q[1];
	wire lock3 = (protect_level_q == `TMOP_PROTECT_LEVEL_L3);
	wire out_mode = (ch_mode_q == `TMOP_MODE_OUTPUT);

	// Break detection
	wire brk_pin_act = break_polarity_q ? break_input_pin : ~break_input_pin;
	wire brk_active = break_enable_q & (brk_pin_act | clock_monitor);
	wire primary_output_enable_eff = primary_output_enable_q & ~brk_active;
	assign primary_output_enable = primary_output_enable_eff;

	// AXI channel state
	always @(posedge clk) begin
		if (!nrst) begin
			aw_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_got_q <= 1'b0;
			w_data_q <= 16'h0000;
			w_strb_q <= 2'b00;
			bvalid_q <= 1'b0;
			bresp_q <= `TMOP_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `TMOP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				w_data_q <= s_axi_wdata[15:0];
				w_strb_q <= s_axi_wstrb[1:0];
			end
			if (wr_go) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? `TMOP_RESP_OKAY : `TMOP_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= {16'h0000, rd_view[15:0]};
				rresp_q <= rd_view[16] ? `TMOP_RESP_OKAY : `TMOP_RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Primary output enable
	always @(posedge clk) begin
		if (!nrst) begin
			primary_output_enable_q <= 1'b0;
		end else if (brk_active) begin
			primary_output_enable_q <= 1'b0;
		end else if (update_event && auto_output_enable_q) begin
			primary_output_enable_q <= 1'b1;
		end else if (wr_protect_level) begin
			primary_output_enable_q <= wd[`TMOP_B_PRIMARY_OUTPUT_ENABLE];
		end
	end

	// Burst index
	always @(posedge clk) begin
		if (!nrst) begin
			burst_idx_q <= 5'h00;
		end else if (wr_en && wr_addr == `TMOP_OFF_BURST_CFG) begin
			burst_idx_q <= 5'h00;
		end else if ((wr_go && aw_is_win) || (ar_fire && ar_is_win)) begin
			if (burst_idx_q >= burst_count_q) begin
				burst_idx_q <= 5'h00;
			end else begin
				burst_idx_q <= burst_idx_q + 5'h01;
			end
		end
	end

	// Register writes
	always @(posedge clk) begin
		if (!nrst) begin
			idle_level_q <= 1'b0;
			compl_idle_level_q <= 1'b0;
			ch_mode_q <= 2'b00;
			compare_shadow_enable_q <= 1'b0;
			compare_action_q <= 3'b000;
			channel_enable_bit_q <= 1'b0;
			channel_polarity_bit_q <= 1'b0;
			compl_channel_enable_bit_q <= 1'b0;
			compl_polarity_bit_q <= 1'b0;
			compare_value_q <= `TMOP_RST_REG;
			auto_output_enable_q <= 1'b0;
			break_polarity_q <= 1'b0;
			break_enable_q <= 1'b0;
			run_offstate_select_q <= 1'b0;
			idle_offstate_select_q <= 1'b0;
			protect_level_q <= `TMOP_PROTECT_LEVEL_OFF;
			protect_level_locked_q <= 1'b0;
			dead_time_config_q <= 8'h00;
			burst_count_q <= 5'h00;
			burst_start_index_q <= 5'h00;
			same_value_write_skip_q <= 1'b0;
			output_off_select_q <= 1'b0;
		end else if (wr_en) begin
			case (wr_addr)
				`TMOP_OFF_IDLE_CTL: begin
					if (!lock1) begin
						idle_level_q <= wd[`TMOP_B_IDLE];
						compl_idle_level_q <= wd[`TMOP_B_IDLE_N];
					end
				end
				`TMOP_OFF_CMP_MODE: begin
					ch_mode_q <= wd[`TMOP_B_MODE_HI:`TMOP_B_MODE_LO];
					if (!(lock3 && out_mode)) begin
						compare_shadow_enable_q <= wd[`TMOP_B_SHADOW];
						compare_action_q <= wd[`TMOP_B_ACT_HI:`TMOP_B_ACT_LO];
					end
				end
				`TMOP_OFF_CHAN_EN: begin
					channel_enable_bit_q <= wd[`TMOP_B_EN];
					compl_channel_enable_bit_q <= wd[`TMOP_B_NEN];
					if (!(lock2 && out_mode)) begin
						channel_polarity_bit_q <= wd[`TMOP_B_POL];
						compl_polarity_bit_q <= wd[`TMOP_B_NPOL];
					end
				end
				`TMOP_OFF_CMP_VALUE: begin
					if (!(same_value_write_skip_q && wd == compare_value_q)) begin
						compare_value_q <= wd;
					end
				end
				`TMOP_OFF_PROTECT: begin
					if (!lock1) begin
						auto_output_enable_q <= wd[`TMOP_B_AUTO_OUTPUT_ENABLE];
						break_polarity_q <= wd[`TMOP_B_BREAK_POLARITY];
						break_enable_q <= wd[`TMOP_B_BREAK_ENABLE];
						dead_time_config_q <= wd[`TMOP_B_DT_HI:`TMOP_B_DT_LO];
					end
					if (!lock2) begin
						run_offstate_select_q <= wd[`TMOP_B_ROS];
						idle_offstate_select_q <= wd[`TMOP_B_IOS];
					end
					if (!protect_level_locked_q) begin
						protect_level_q <= wd[`TMOP_B_PROTECT_LEVEL_HI:`TMOP_B_PROTECT_LEVEL_LO];
					end
					protect_level_locked_q <= 1'b1;
				end
				`TMOP_OFF_BURST_CFG: begin
					burst_count_q <= wd[`TMOP_B_CNT_HI:`TMOP_B_CNT_LO];
					burst_start_index_q <= wd[`TMOP_B_START_HI:`TMOP_B_START_LO];
				end
				`TMOP_OFF_OPTION: begin
					same_value_write_skip_q <= wd[`TMOP_B_SKIP];
					output_off_select_q <= wd[`TMOP_B_OUTPUT_OFF_SELECT];
				end
				default: begin
				end
			endcase
		end
	end

	// Dead-time insertion on reference edges
	always @(posedge clk) begin
		if (!nrst) begin
			ref_q <= 1'b0;
			main_q <= 1'b0;
			compl_q <= 1'b0;
			dt_cnt_q <= 10'h000;
		end else if (compare_ref != ref_q) begin
			ref_q <= compare_ref;
			dt_cnt_q <= dt_len(dead_time_config_q);
			if (compare_ref) begin
				compl_q <= 1'b0;
			end else begin
				main_q <= 1'b0;
			end
		end else if (dt_cnt_q != 10'h000) begin
			dt_cnt_q <= dt_cnt_q - 10'h001;
		end else begin
			main_q <= ref_q;
			compl_q <= ~ref_q;
		end
	end

	// Output stage
	always @* begin
		channel_out = 1'b0;
		channel_out_oe = 1'b0;
		channel_out_compl = 1'b0;
		channel_out_compl_oe = 1'b0;
		if (out_mode) begin
			if (primary_output_enable_eff) begin
				channel_out_oe = channel_enable_bit_q | run_offstate_select_q;
				channel_out_compl_oe = compl_channel_enable_bit_q | run_offstate_select_q;
				channel_out = (channel_enable_bit_q & main_q) ^ channel_polarity_bit_q;
				channel_out_compl = (compl_channel_enable_bit_q & compl_q) ^ compl_polarity_bit_q;
			end else if (idle_offstate_select_q) begin
				channel_out_oe = channel_enable_bit_q;
				channel_out_compl_oe = compl_channel_enable_bit_q;
				channel_out = idle_level_q;
				channel_out_compl = compl_idle_level_q;
			end else if (output_off_select_q) begin
				channel_out_oe = 1'b0;
				channel_out_compl_oe = 1'b0;
			end
		end
	end

endmodule // tmop_top

// File: test/tmop_asserts.sv
`timescale 1ns/1ps
module tmop_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Events and outputs
	input wire logic update_event,
	input wire logic primary_output_enable,
	input wire logic channel_out,
	input wire logic channel_out_oe,
	input wire logic channel_out_compl,
	input wire logic channel_out_compl_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Bus answers stand until taken
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	b_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	r_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("read upper half not zero");
	w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	primary_output_enable_rise_a: assert property ($rose(primary_output_enable) && !$past(update_event)
		|-> ##[0:1] s_axi_bvalid) else $error("output enable rose without cause");
	no_overlap_a: assert property (!(channel_out && channel_out_oe && channel_out_compl
		&& channel_out_compl_oe)) else $error("both outputs active");
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property ($fell(primary_output_enable));
	cover property ($rose(channel_out));
	cover property ($rose(s_axi_rvalid));
endmodule // tmop_asserts

bind tmop_top tmop_asserts tmop_asserts_inst (.*);

// File: test/tmop_stage.sv
`timescale 1ns/1ps
module tmop_stage (
	// Gate drive from the block
	input wire logic clk,
	input wire logic channel_out,
	input wire logic channel_out_oe,
	input wire logic channel_out_compl,
	input wire logic channel_out_compl_oe,
	// Fault request and its active level
	input wire logic trip,
	input wire logic trip_hi,
	// Fault line and shoot-through count
	output wire logic break_input_pin,
	output logic [7:0] shoot
);
	// Undriven gates are pulled off
	wire hi_on = channel_out_oe & channel_out;
	wire lo_on = channel_out_compl_oe & channel_out_compl;
	// Fault line rests at its inactive level
	assign break_input_pin = trip ? trip_hi : ~trip_hi;
	initial shoot = 8'h00;
	always @(posedge clk) begin
		if (hi_on && lo_on) begin
			shoot <= shoot + 8'h01;
		end
	end
endmodule // tmop_stage

// File: test/tmop_top_tb.sv
`timescale 1ns/1ps
module tmop_top_tb;
	logic clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic update_event, compare_ref, clock_monitor, trip, trip_hi;
	logic [7:0] s_axi_awaddr, s_axi_araddr, shoot;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, break_input_pin;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire channel_out, channel_out_oe, channel_out_compl, channel_out_compl_oe, primary_output_enable;
	int miscompares, n_tests;
	tmop_top tmop_top_inst (.*);
	tmop_stage tmop_stage_inst (.*);
	always #25 clk = ~clk;

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rst;
		@(posedge clk);
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic da, dw, ha, hw;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		da = 0;
		dw = 0;
		while (!(da && dw)) begin
			@(negedge clk);
			ha = !da && s_axi_awready;
			hw = !dw && s_axi_wready;
			@(posedge clk);
			if (ha) begin
				da = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (hw) begin
				dw = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(negedge clk); while (!s_axi_bvalid);
		chk("bresp", 32'(er), 32'(s_axi_bresp));
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk); while (!s_axi_rvalid);
		chk("rdata", 32'(e), s_axi_rdata);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask
	task po(input logic e);
		@(negedge clk);
		chk("primary_output_enable", 32'(e), 32'(primary_output_enable));
	endtask
	task oe(input logic e);
		@(negedge clk);
		chk("oe", 32'({e, e}), 32'({channel_out_oe, channel_out_compl_oe}));
	endtask
	task trp(input logic t, input logic h, input logic c);
		@(posedge clk);
		trip <= t;
		trip_hi <= h;
		clock_monitor <= c;
	endtask
	task upd;
		@(posedge clk);
		update_event <= 1'b1;
		@(posedge clk);
		update_event <= 1'b0;
	endtask
	task automatic meas(input logic v, input int len);
		int n;
		@(posedge clk);
		compare_ref <= v;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((v ? channel_out : channel_out_compl) !== 1'b1 && n < 700);
		chk("dead time", 1, 32'(n >= len + 2 && n <= len + 4));
	endtask

	task t_regs;
		rst;
		rc(8'h44, 16'h0000, 2'h0);
		rc(8'h48, 16'h0000, 2'h0);
		rc(8'hfc, 16'h0000, 2'h0);
		rc(8'h80, 16'h0000, 2'h2);
		wr(8'h80, 16'h1234, 2'h2);
		wr(8'hfc, 16'h0003, 2'h0);
		rc(8'hfc, 16'h0003, 2'h0);
	endtask
	task t_break;
		rst;
		trp(0, 0, 0);
		wr(8'h44, 16'h9000, 2'h0);
		po(1);
		trp(1, 0, 0);
		po(0);
		trp(0, 0, 0);
		po(0);
		wr(8'h44, 16'ha000, 2'h0);
		trp(0, 1, 0);
		wr(8'h44, 16'hb000, 2'h0);
		po(1);
		trp(1, 1, 0);
		po(0);
		trp(0, 1, 0);
		wr(8'h44, 16'h8000, 2'h0);
		trp(1, 1, 1);
		po(1);
		wr(8'h44, 16'h9000, 2'h0);
		po(0);
		trp(0, 1, 0);
	endtask
	task t_auto;
		rst;
		wr(8'h44, 16'h7000, 2'h0);
		po(0);
		upd;
		po(1);
		trp(1, 1, 0);
		upd;
		trp(0, 1, 0);
		po(0);
		wr(8'h44, 16'h3000, 2'h0);
		upd;
		po(0);
	endtask
	task t_protect_level;
		logic [1:0] lv;
		for (int k = 0; k < 4; k++) begin
			lv = k[1:0];
			rst;
			wr(8'h20, 16'h0002, 2'h0);
			wr(8'h18, 16'h0070, 2'h0);
			wr(8'h04, 16'h0100, 2'h0);
			wr(8'h44, {6'h0f, lv, 8'hab}, 2'h0);
			wr(8'h44, 16'h0000, 2'h0);
			wr(8'h04, 16'h0000, 2'h0);
			wr(8'h20, 16'h0000, 2'h0);
			wr(8'h18, 16'h0000, 2'h0);
			rc(8'h44, (lv == 0) ? 16'h0000 : {(lv > 1) ? 6'h0f : 6'h0c, lv, 8'hab}, 2'h0);
			rc(8'h04, (lv == 0) ? 16'h0000 : 16'h0100, 2'h0);
			rc(8'h20, (lv > 1) ? 16'h0002 : 16'h0000, 2'h0);
			rc(8'h18, (lv == 3) ? 16'h0070 : 16'h0000, 2'h0);
		end
	endtask
	task t_burst;
		rst;
		wr(8'h44, 16'h0800, 2'h0);
		wr(8'h48, 16'h0211, 2'h0);
		rc(8'h4c, 16'h0800, 2'h0);
		rc(8'h4c, 16'h0211, 2'h0);
		rc(8'h4c, 16'h0000, 2'h2);
		rc(8'h4c, 16'h0800, 2'h0);
		wr(8'h48, 16'h010d, 2'h0);
		wr(8'h4c, 16'hbeef, 2'h0);
		wr(8'h4c, 16'h1111, 2'h2);
		rc(8'h34, 16'hbeef, 2'h0);
	endtask
	task t_outs;
		rst;
		wr(8'h20, 16'h0005, 2'h0);
		wr(8'h44, 16'h0000, 2'h0);
		oe(0);
		wr(8'hfc, 16'h0001, 2'h0);
		oe(0);
		wr(8'h44, 16'h0400, 2'h0);
		oe(1);
		wr(8'h44, 16'h8800, 2'h0);
		oe(1);
		wr(8'h20, 16'h0000, 2'h0);
		wr(8'h44, 16'h8000, 2'h0);
		oe(0);
	endtask
	task t_dt;
		logic [7:0] dts [4];
		int lens [4];
		dts = '{8'h05, 8'h85, 8'hc3, 8'he3};
		lens = '{5, 138, 280, 560};
		rst;
		wr(8'h20, 16'h0005, 2'h0);
		for (int k = 0; k < 4; k++) begin
			wr(8'h44, {8'h88, dts[k]}, 2'h0);
			meas(1'b1, lens[k]);
			meas(1'b0, lens[k]);
		end
		chk("shoot", 0, 32'(shoot));
	endtask
	task test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		{clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{update_event, compare_ref, clock_monitor, trip, trip_hi} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		s_axi_wstrb = 4'hf;
		t_regs;
		t_break;
		t_auto;
		t_protect_level;
		t_burst;
		t_outs;
		t_dt;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done;
	end
endmodule // tmop_top_tb
